// ===== rtl/fault_seq_pkg.sv
// Constants and carrier types for the PWM fault and restart sequencer.
package fault_seq_pkg;
    localparam int unsigned CLK_HZ = 50_000_000;
    // Soft-start interval in microseconds.
    localparam int unsigned SOFT_START_US = 4000;
    // Fault timer in milliseconds.
    localparam int unsigned FAULT_TIMER_MS = 70;
    // Brown-out debounce in microseconds.
    localparam int unsigned BO_FILTER_US = 50;
    // Supply overvoltage confirmation in microseconds.
    localparam int unsigned VCC_OVP_US = 20;
    localparam int unsigned SOFT_START_CYC = SOFT_START_US * (CLK_HZ / 1_000_000);
    localparam int unsigned FAULT_TIMER_CYC = FAULT_TIMER_MS * (CLK_HZ / 1_000);
    localparam int unsigned BO_FILTER_CYC = BO_FILTER_US * (CLK_HZ / 1_000_000);
    localparam int unsigned VCC_OVP_CYC = VCC_OVP_US * (CLK_HZ / 1_000_000);
    // Consecutive oscillator cycles before a line or current-sense overvoltage latch.
    localparam logic [2:0] LATCH_COUNT = 3'h4;
    // Supply charge-discharge cycles spent in a double hiccup.
    localparam logic [1:0] HICCUP_CYCLES = 2'h2;
    localparam int unsigned TW = 22;
    localparam logic [TW-1:0] T_ZERO = 22'h0;
    localparam logic [TW-1:0] T_ONE = 22'h1;

    typedef enum logic [2:0] {
        ST_WAIT_LINE,
        ST_WAIT_VCC,
        ST_SOFT_START,
        ST_RUN,
        ST_HICCUP,
        ST_LATCHED
    } seq_state_e;

    // Digitized comparator results from the analog front end.
    typedef struct packed {
        logic line_ok;        // Line sense above turn-on level.
        logic line_above_off; // Line sense above turn-off level.
        logic line_ovp;       // Line sense above overvoltage latch level.
        logic cs_ovp;         // Current sense above its latch level.
        logic switch_off;     // Power switch in its off-time.
        logic osc_tick;       // One pulse per oscillator cycle.
        logic vcc_on;         // Supply above turn-on threshold.
        logic vcc_min;        // Supply above minimum (undervoltage) level.
        logic vcc_reset_ok;   // Supply above reset level.
        logic vcc_ovp;        // Supply above overvoltage level.
        logic peak_limit;     // Maximum peak-current limit reached.
        logic fb_fold;        // Feedback below upper reduction threshold.
        logic fb_fold_end;    // Feedback below lower reduction threshold.
        logic fb_freeze;      // Feedback below freeze threshold.
        logic fb_skip;        // Feedback below skip threshold.
    } comp_s;
endpackage

// ===== rtl/offline_pwm_fault_restart_sequencer.sv
// Fault, latch and restart sequencer of the offline PWM controller.
`timescale 1ns/100ps
module offline_pwm_fault_restart_sequencer #(
    parameter int unsigned SOFT_START_CYC = fault_seq_pkg::SOFT_START_CYC,
    parameter int unsigned FAULT_TIMER_CYC = fault_seq_pkg::FAULT_TIMER_CYC,
    parameter logic LATCHED_OCP = 1'b0,
    parameter logic AUTO_VARIANT = 1'b0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire fault_seq_pkg::comp_s comp_in,
    output logic drive_enable,
    output logic soft_start_active,
    output logic opp_enable,
    output logic jitter_enable,
    output logic fold_active,
    output logic fold_floor,
    output logic peak_frozen,
    output logic skip_active,
    output logic error_flag,
    output logic latched_off,
    output logic hiccup_active
);
    localparam logic [fault_seq_pkg::TW-1:0] SS_LAST = fault_seq_pkg::TW'(SOFT_START_CYC - 1);
    localparam logic [fault_seq_pkg::TW-1:0] FT_LAST = fault_seq_pkg::TW'(FAULT_TIMER_CYC - 1);
    localparam logic [fault_seq_pkg::TW-1:0] BO_LAST =
        fault_seq_pkg::TW'(fault_seq_pkg::BO_FILTER_CYC - 1);
    localparam logic [fault_seq_pkg::TW-1:0] OV_LAST =
        fault_seq_pkg::TW'(fault_seq_pkg::VCC_OVP_CYC - 1);

    typedef struct packed {
        fault_seq_pkg::comp_s s1;
        fault_seq_pkg::comp_s s2;
        logic vcc_on_prev;
        logic vcc_min_prev;
        fault_seq_pkg::seq_state_e st;
        logic line_good;
        logic [fault_seq_pkg::TW-1:0] bo_cnt;
        logic [fault_seq_pkg::TW-1:0] ss_cnt;
        logic [fault_seq_pkg::TW-1:0] ft_cnt;
        logic [fault_seq_pkg::TW-1:0] ov_cnt;
        logic [2:0] line_ov_cnt;
        logic [2:0] cs_ov_cnt;
        logic [1:0] hic_cnt;
        logic err;
        logic first_done;
        logic drive;
        logic ss;
        logic over_power_compensation;
        logic jit;
        logic fold;
        logic floor_q;
        logic freeze;
        logic skip;
        logic latch;
        logic hic;
    } state_s;

    state_s r_q, r_d;

    logic vcc_rise, vcc_fall;
    logic line_latch, line_auto, cs_latch, vcc_ovp_hit, timer_done, uvlo_ev;

    assign vcc_rise = r_q.s2.vcc_on & ~r_q.vcc_on_prev;
    assign vcc_fall = ~r_q.s2.vcc_min & r_q.vcc_min_prev;

    always_comb begin
        r_d = r_q;
        r_d.s1 = comp_in;
        r_d.s2 = r_q.s1;
        r_d.vcc_on_prev = r_q.s2.vcc_on;
        r_d.vcc_min_prev = r_q.s2.vcc_min;
        line_latch = 1'b0;
        line_auto = 1'b0;
        cs_latch = 1'b0;
        vcc_ovp_hit = 1'b0;
        timer_done = 1'b0;
        uvlo_ev = 1'b0;

        // A change of line level counts only after it has held for the filter time.
        if (r_q.s2.line_ok == r_q.line_good) begin
            r_d.bo_cnt = fault_seq_pkg::T_ZERO;
        end else if (r_q.bo_cnt == BO_LAST) begin
            r_d.line_good = r_q.s2.line_ok;
            r_d.bo_cnt = fault_seq_pkg::T_ZERO;
        end else begin
            r_d.bo_cnt = r_q.bo_cnt + fault_seq_pkg::T_ONE;
        end

        // Counters clear on any oscillator cycle without the overvoltage.
        if (r_q.s2.osc_tick) begin
            if (r_q.s2.line_ovp) begin
                if (r_q.line_ov_cnt != fault_seq_pkg::LATCH_COUNT) begin
                    r_d.line_ov_cnt = r_q.line_ov_cnt + 3'h1;
                end
            end else begin
                r_d.line_ov_cnt = 3'h0;
            end
            // Sampling only in off-time keeps the on-time current spike out.
            if (r_q.s2.cs_ovp & r_q.s2.switch_off) begin
                if (r_q.cs_ov_cnt != fault_seq_pkg::LATCH_COUNT) begin
                    r_d.cs_ov_cnt = r_q.cs_ov_cnt + 3'h1;
                end
            end else begin
                r_d.cs_ov_cnt = 3'h0;
            end
        end
        line_latch = (r_q.line_ov_cnt == fault_seq_pkg::LATCH_COUNT) & ~AUTO_VARIANT;
        line_auto = (r_q.line_ov_cnt == fault_seq_pkg::LATCH_COUNT) & AUTO_VARIANT;
        cs_latch = (r_q.cs_ov_cnt == fault_seq_pkg::LATCH_COUNT);

        if (!r_q.s2.vcc_ovp) begin
            r_d.ov_cnt = fault_seq_pkg::T_ZERO;
        end else if (r_q.ov_cnt == OV_LAST) begin
            vcc_ovp_hit = 1'b1;
        end else begin
            r_d.ov_cnt = r_q.ov_cnt + fault_seq_pkg::T_ONE;
        end

        // Error flag and fault timer run only while switching.
        if (r_q.st == fault_seq_pkg::ST_RUN || r_q.st == fault_seq_pkg::ST_SOFT_START) begin
            if (r_q.s2.peak_limit) begin
                r_d.err = 1'b1;
            end
            if (r_q.err) begin
                if (r_q.ft_cnt == FT_LAST) begin
                    timer_done = 1'b1;
                end else begin
                    r_d.ft_cnt = r_q.ft_cnt + fault_seq_pkg::T_ONE;
                end
            end
        end
        uvlo_ev = vcc_fall & (r_q.st == fault_seq_pkg::ST_RUN ||
                              r_q.st == fault_seq_pkg::ST_SOFT_START);

        unique case (r_q.st)
            fault_seq_pkg::ST_WAIT_LINE: begin
                if (r_q.line_good) begin
                    r_d.latch = 1'b0;
                    r_d.err = 1'b0;
                    r_d.ft_cnt = fault_seq_pkg::T_ZERO;
                    r_d.st = fault_seq_pkg::ST_WAIT_VCC;
                end
            end
            fault_seq_pkg::ST_WAIT_VCC: begin
                if (!r_q.line_good) begin
                    r_d.st = fault_seq_pkg::ST_WAIT_LINE;
                end else if (vcc_rise | r_q.s2.vcc_on) begin
                    r_d.ss_cnt = fault_seq_pkg::T_ZERO;
                    r_d.st = fault_seq_pkg::ST_SOFT_START;
                end
            end
            fault_seq_pkg::ST_SOFT_START, fault_seq_pkg::ST_RUN: begin
                if (r_q.st == fault_seq_pkg::ST_SOFT_START) begin
                    if (r_q.ss_cnt == SS_LAST) begin
                        r_d.st = fault_seq_pkg::ST_RUN;
                        r_d.first_done = 1'b1;
                    end else begin
                        r_d.ss_cnt = r_q.ss_cnt + fault_seq_pkg::T_ONE;
                    end
                end
                if (!r_q.line_good) begin
                    r_d.st = fault_seq_pkg::ST_WAIT_LINE;
                end else if (line_latch | cs_latch |
                             (vcc_ovp_hit & ~AUTO_VARIANT)) begin
                    r_d.st = fault_seq_pkg::ST_LATCHED;
                end else if (LATCHED_OCP & ~r_q.first_done & r_q.err & uvlo_ev) begin
                    r_d.st = fault_seq_pkg::ST_LATCHED;
                end else if (LATCHED_OCP & timer_done) begin
                    r_d.st = fault_seq_pkg::ST_LATCHED;
                end else if (timer_done | line_auto | (vcc_ovp_hit & AUTO_VARIANT) |
                             uvlo_ev) begin
                    r_d.hic_cnt = 2'h0;
                    r_d.st = fault_seq_pkg::ST_HICCUP;
                end
            end
            fault_seq_pkg::ST_HICCUP: begin
                // Saturating, so an extra supply fall cannot wrap the count past the exit value.
                if (vcc_fall) begin
                    if (r_q.hic_cnt != fault_seq_pkg::HICCUP_CYCLES) begin
                        r_d.hic_cnt = r_q.hic_cnt + 2'h1;
                    end
                end
                if (!r_q.line_good) begin
                    r_d.st = fault_seq_pkg::ST_WAIT_LINE;
                end else if (r_q.hic_cnt == fault_seq_pkg::HICCUP_CYCLES && vcc_rise) begin
                    r_d.err = 1'b0;
                    r_d.ft_cnt = fault_seq_pkg::T_ZERO;
                    r_d.ss_cnt = fault_seq_pkg::T_ZERO;
                    r_d.st = fault_seq_pkg::ST_SOFT_START;
                end
            end
            fault_seq_pkg::ST_LATCHED: begin
                r_d.latch = 1'b1;
                if ((vcc_fall & ~r_q.s2.line_above_off) | ~r_q.s2.vcc_reset_ok) begin
                    r_d.latch = 1'b0;
                    r_d.err = 1'b0;
                    r_d.ft_cnt = fault_seq_pkg::T_ZERO;
                    r_d.first_done = 1'b0;
                    r_d.st = fault_seq_pkg::ST_WAIT_LINE;
                end
            end
            default: r_d.st = fault_seq_pkg::ST_WAIT_LINE;
        endcase

        // Output flops follow the next state or the synchronized feedback comparators, so each output is registered.
        r_d.drive = (r_d.st == fault_seq_pkg::ST_RUN || r_d.st == fault_seq_pkg::ST_SOFT_START)
                    & ~r_q.s2.fb_skip;
        r_d.ss = (r_d.st == fault_seq_pkg::ST_SOFT_START);
        r_d.fold = r_q.s2.fb_fold;
        r_d.floor_q = r_q.s2.fb_fold_end;
        r_d.freeze = r_q.s2.fb_freeze;
        r_d.skip = r_q.s2.fb_skip;
        r_d.over_power_compensation = r_d.drive & ~r_q.s2.fb_fold;
        r_d.jit = r_d.drive;
        r_d.hic = (r_d.st == fault_seq_pkg::ST_HICCUP);
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            r_q <= '0;
        end else begin
            r_q <= r_d;
        end
    end

    assign drive_enable = r_q.drive;
    assign soft_start_active = r_q.ss;
    assign opp_enable = r_q.over_power_compensation;
    assign jitter_enable = r_q.jit;
    assign fold_active = r_q.fold;
    assign fold_floor = r_q.floor_q;
    assign peak_frozen = r_q.freeze;
    assign skip_active = r_q.skip;
    assign error_flag = r_q.err;
    assign latched_off = r_q.latch;
    assign hiccup_active = r_q.hic;

    chk_latch_no_drive: assert property (@(posedge clk) disable iff (!rst_n)
        r_q.st == fault_seq_pkg::ST_LATCHED |=> !drive_enable)
        else $error("drive active while latched");
    chk_line_low_stop: assert property (@(posedge clk) disable iff (!rst_n)
        !r_q.line_good |=> !drive_enable)
        else $error("drive active with line low");
    chk_opp_fold_off: assert property (@(posedge clk) disable iff (!rst_n)
        fold_active |-> !opp_enable)
        else $error("over-power compensation on in fold region");
    chk_jitter_with_drive: assert property (@(posedge clk) disable iff (!rst_n)
        jitter_enable == drive_enable)
        else $error("modulation not following drive");
    chk_skip_no_drive: assert property (@(posedge clk) disable iff (!rst_n)
        $past(r_q.s2.fb_skip) |-> !drive_enable)
        else $error("drive during skip");
    chk_line_count_latch: assert property (@(posedge clk) disable iff (!rst_n)
        (r_q.line_ov_cnt == fault_seq_pkg::LATCH_COUNT) && !AUTO_VARIANT && r_q.line_good &&
        (r_q.st == fault_seq_pkg::ST_RUN) |=> r_q.st == fault_seq_pkg::ST_LATCHED)
        else $error("line overvoltage did not latch");
    chk_cs_counter_clear: assert property (@(posedge clk) disable iff (!rst_n)
        r_q.s2.osc_tick && !(r_q.s2.cs_ovp && r_q.s2.switch_off) |=> r_q.cs_ov_cnt == 3'h0)
        else $error("current-sense counter not cleared");
    chk_hiccup_exit: assert property (@(posedge clk) disable iff (!rst_n)
        r_q.st == fault_seq_pkg::ST_HICCUP && r_d.st == fault_seq_pkg::ST_SOFT_START
        |-> r_q.hic_cnt == fault_seq_pkg::HICCUP_CYCLES)
        else $error("hiccup ended early");
    chk_soft_start_len: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(soft_start_active) |-> soft_start_active [*8])
        else $error("soft-start too short");

    // Sequencing decisions, checked one state step after their cause except the hiccup no-drive and timer bound checks.
    chk_cs_count_latch: assert property (@(posedge clk) disable iff (!rst_n)
        (r_q.cs_ov_cnt == fault_seq_pkg::LATCH_COUNT) && r_q.line_good &&
        (r_q.st == fault_seq_pkg::ST_RUN) |=> r_q.st == fault_seq_pkg::ST_LATCHED)
        else $error("current-sense overvoltage did not latch");

    chk_line_counter_clear: assert property (@(posedge clk) disable iff (!rst_n)
        r_q.s2.osc_tick && !r_q.s2.line_ovp |=> r_q.line_ov_cnt == 3'h0)
        else $error("line counter not cleared");

    chk_vcc_ovp_fault: assert property (@(posedge clk) disable iff (!rst_n)
        vcc_ovp_hit && r_q.line_good && (r_q.st == fault_seq_pkg::ST_RUN) &&
        !line_latch && !cs_latch && !timer_done
        |=> r_q.st == (AUTO_VARIANT ? fault_seq_pkg::ST_HICCUP : fault_seq_pkg::ST_LATCHED))
        else $error("supply overvoltage not handled");

    chk_ocp_timer_latch: assert property (@(posedge clk) disable iff (!rst_n)
        LATCHED_OCP && timer_done && r_q.line_good && (r_q.st == fault_seq_pkg::ST_RUN)
        |=> r_q.st == fault_seq_pkg::ST_LATCHED)
        else $error("timer expiry did not latch");

    chk_timer_hiccup: assert property (@(posedge clk) disable iff (!rst_n)
        !LATCHED_OCP && timer_done && r_q.line_good && (r_q.st == fault_seq_pkg::ST_RUN) &&
        !line_latch && !cs_latch && !vcc_ovp_hit |=> r_q.st == fault_seq_pkg::ST_HICCUP)
        else $error("timer expiry did not hiccup");

    chk_uvlo_hiccup: assert property (@(posedge clk) disable iff (!rst_n)
        uvlo_ev && !r_q.err && r_q.line_good && !line_latch && !cs_latch && !vcc_ovp_hit
        |=> r_q.st == fault_seq_pkg::ST_HICCUP)
        else $error("undervoltage did not hiccup");

    chk_general_reset: assert property (@(posedge clk) disable iff (!rst_n)
        r_q.st == fault_seq_pkg::ST_WAIT_LINE && r_q.line_good |=> !error_flag && !latched_off)
        else $error("general reset left a fault");

    chk_restart_immediate: assert property (@(posedge clk) disable iff (!rst_n)
        r_q.st == fault_seq_pkg::ST_WAIT_VCC && r_q.line_good && r_q.s2.vcc_on
        |=> r_q.st == fault_seq_pkg::ST_SOFT_START)
        else $error("restart not immediate");

    chk_latch_reset_exit: assert property (@(posedge clk) disable iff (!rst_n)
        r_q.st == fault_seq_pkg::ST_LATCHED && !r_q.s2.vcc_reset_ok
        |=> r_q.st == fault_seq_pkg::ST_WAIT_LINE && !latched_off)
        else $error("latch not cleared by supply reset");

    chk_hiccup_no_drive: assert property (@(posedge clk) disable iff (!rst_n)
        r_q.st == fault_seq_pkg::ST_HICCUP |-> !drive_enable)
        else $error("drive active in hiccup");

    chk_timer_bound: assert property (@(posedge clk) disable iff (!rst_n)
        r_q.ft_cnt <= FT_LAST)
        else $error("fault timer overran");

    chk_first_done_latch: assert property (@(posedge clk) disable iff (!rst_n)
        LATCHED_OCP && !r_q.first_done && r_q.err && uvlo_ev && r_q.line_good
        |=> r_q.st == fault_seq_pkg::ST_LATCHED)
        else $error("pre-short undervoltage did not latch");
endmodule

// ===== sim/power_stage_model.sv
// Behavioural power stage: comparator levels, oscillator ticks and switch off-time.
`timescale 1ns/100ps
module power_stage_model #(
    parameter int OSC_DIV = 8
) (
    input wire logic clk,
    input wire logic drive_enable,
    input wire fault_seq_pkg::comp_s levels,
    output fault_seq_pkg::comp_s comp
);
    logic [7:0] cnt_q = 8'h0;
    always @(posedge clk) begin
        cnt_q <= (cnt_q == 8'(OSC_DIV - 1)) ? 8'h0 : cnt_q + 8'h1;
        comp <= levels;
        // One clock wide at the cycle end, inside the off-time, so it is counted once.
        comp.osc_tick <= (cnt_q == 8'(OSC_DIV - 1));
        // With the gate held off, the whole cycle is off-time.
        comp.switch_off <= !drive_enable || (cnt_q >= 8'(OSC_DIV / 2));
    end
endmodule

// ===== sim/tb_offline_pwm_fault_restart_sequencer.sv
// Self-checking bench for the PWM fault and restart sequencer.
`timescale 1ns/100ps
module tb_offline_pwm_fault_restart_sequencer;
    localparam int DRV = 10, SS = 9, OVER_POWER_COMPENSATION = 8, JIT = 7, ERR = 2, LAT = 1, HIC = 0;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    fault_seq_pkg::comp_s lv = '0;
    fault_seq_pkg::comp_s comp;
    wire [10:0] o;
    int mismatches = 0;
    int total_checks = 0;
    always #10 clk = ~clk;
    power_stage_model #(.OSC_DIV(8)) stage_u (.clk(clk), .drive_enable(o[DRV]),
        .levels(lv), .comp(comp));
    offline_pwm_fault_restart_sequencer #(.SOFT_START_CYC(16), .FAULT_TIMER_CYC(32)) dut_u (
        .clk(clk), .rst_n(rst_n), .comp_in(comp), .drive_enable(o[10]),
        .soft_start_active(o[9]), .opp_enable(o[8]), .jitter_enable(o[7]),
        .fold_active(o[6]), .fold_floor(o[5]), .peak_frozen(o[4]), .skip_active(o[3]),
        .error_flag(o[2]), .latched_off(o[1]), .hiccup_active(o[0]));
    task automatic check(input string what, input logic seen, input logic exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s expected %b seen %b", what, exp, seen);
        end
    endtask
    task automatic run(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic ticks(input int n);
        repeat (n) @(posedge clk iff comp.osc_tick);
    endtask
    // Outputs change only in the update region, so reading at the edge sees settled values.
    task automatic wait_bit(input string what, input int i, input logic v, input int lim);
        int k;
        k = 0;
        while (o[i] !== v && k < lim) begin
            @(posedge clk);
            k++;
        end
        check(what, o[i], v);
    endtask
    task automatic pulse_min();
        lv.vcc_min <= 1'b0;
        run(4);
        lv.vcc_min <= 1'b1;
        run(4);
    endtask
    task automatic hiccup_exit();
        lv.vcc_on <= 1'b0;
        pulse_min();
        check("drive", o[DRV], 1'b0);
        check("hiccup", o[HIC], 1'b1);
        pulse_min();
        check("drive", o[DRV], 1'b0);
        lv.vcc_on <= 1'b1;
        wait_bit("soft_start", SS, 1'b1, 10);
        wait_bit("soft_start_end", SS, 1'b0, 40);
    endtask
    task automatic t_startup();
        lv.line_ok <= 1'b1;
        run(2600);
        check("drive", o[DRV], 1'b0);
        lv.vcc_on <= 1'b1;
        wait_bit("soft_start", SS, 1'b1, 8);
        check("drive", o[DRV], 1'b1);
        wait_bit("soft_start_end", SS, 1'b0, 40);
        check("drive", o[DRV], 1'b1);
        check("jitter", o[JIT], 1'b1);
        check("opp", o[OVER_POWER_COMPENSATION], 1'b1);
        $display("test startup done");
    endtask
    task automatic t_light();
        for (int k = 0; k < 4; k++) begin
            {lv.fb_fold, lv.fb_fold_end, lv.fb_freeze, lv.fb_skip} <= 4'(4'hf << (3 - k));
            run(6);
            check("light_region", o[6-k], 1'b1);
            check("opp", o[OVER_POWER_COMPENSATION], 1'b0);
            if (k < 3) begin
                check("jitter", o[JIT], 1'b1);
            end
        end
        {lv.fb_fold, lv.fb_fold_end, lv.fb_freeze, lv.fb_skip} <= 4'h0;
        run(6);
        check("opp", o[OVER_POWER_COMPENSATION], 1'b1);
        check("skip", o[3], 1'b0);
        $display("test light load done");
    endtask
    task automatic t_uvlo();
        pulse_min();
        check("hiccup", o[HIC], 1'b1);
        check("error", o[ERR], 1'b0);
        hiccup_exit();
        $display("test undervoltage done");
    endtask
    task automatic t_short();
        lv.peak_limit <= 1'b1;
        run(2);
        lv.peak_limit <= 1'b0;
        wait_bit("error", ERR, 1'b1, 6);
        run(20);
        check("hiccup", o[HIC], 1'b0);
        wait_bit("hiccup", HIC, 1'b1, 20);
        check("drive", o[DRV], 1'b0);
        hiccup_exit();
        check("error", o[ERR], 1'b0);
        $display("test short circuit done");
    endtask
    task automatic t_line_ovp();
        lv.line_ovp <= 1'b1;
        run(1);
        ticks(3);
        lv.line_ovp <= 1'b0;
        ticks(2);
        lv.line_ovp <= 1'b1;
        run(1);
        ticks(3);
        run(6);
        check("latched", o[LAT], 1'b0);
        ticks(1);
        wait_bit("latched", LAT, 1'b1, 8);
        check("drive", o[DRV], 1'b0);
        lv.line_ovp <= 1'b0;
        $display("test line overvoltage done");
    endtask
    task automatic t_latch_clear();
        pulse_min();
        check("latched", o[LAT], 1'b1);
        check("drive", o[DRV], 1'b0);
        lv.line_above_off <= 1'b0;
        pulse_min();
        check("latched", o[LAT], 1'b0);
        lv.line_above_off <= 1'b1;
        wait_bit("soft_start", SS, 1'b1, 12);
        wait_bit("soft_start_end", SS, 1'b0, 40);
        $display("test latch clear done");
    endtask
    task automatic t_cs_ovp();
        lv.cs_ovp <= 1'b1;
        run(1);
        ticks(3);
        run(6);
        check("latched", o[LAT], 1'b0);
        wait_bit("latched", LAT, 1'b1, 20);
        check("drive", o[DRV], 1'b0);
        lv.cs_ovp <= 1'b0;
        lv.vcc_reset_ok <= 1'b0;
        wait_bit("latched", LAT, 1'b0, 8);
        lv.vcc_reset_ok <= 1'b1;
        wait_bit("soft_start", SS, 1'b1, 12);
        wait_bit("soft_start_end", SS, 1'b0, 40);
        $display("test current-sense overvoltage done");
    endtask
    task automatic t_vcc_ovp();
        lv.vcc_ovp <= 1'b1;
        run(900);
        check("latched", o[LAT], 1'b0);
        wait_bit("latched", LAT, 1'b1, 200);
        lv.vcc_ovp <= 1'b0;
        lv.vcc_reset_ok <= 1'b0;
        wait_bit("latched", LAT, 1'b0, 8);
        lv.vcc_reset_ok <= 1'b1;
        wait_bit("soft_start", SS, 1'b1, 12);
        wait_bit("soft_start_end", SS, 1'b0, 40);
        $display("test supply overvoltage done");
    endtask
    task automatic t_brownout();
        lv.line_ok <= 1'b0;
        run(2000);
        check("drive", o[DRV], 1'b1);
        wait_bit("drive", DRV, 1'b0, 700);
        lv.line_ok <= 1'b1;
        run(2000);
        check("drive", o[DRV], 1'b0);
        // Supply is already above turn-on, so the restart follows the filter directly.
        wait_bit("soft_start", SS, 1'b1, 700);
        $display("test brown-out done");
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        lv.line_above_off = 1'b1;
        lv.vcc_min = 1'b1;
        lv.vcc_reset_ok = 1'b1;
        run(20);
        rst_n <= 1'b1;
        run(3);
        t_startup();
        t_light();
        t_uvlo();
        t_short();
        t_line_ovp();
        t_latch_clear();
        t_cs_ovp();
        t_vcc_ovp();
        t_brownout();
        report_and_stop();
    end
    initial begin
        run(100000);
        mismatches++;
        $display("BAD watchdog expected finish seen timeout");
        report_and_stop();
    end
endmodule
